// >>> core/trace_pkg.sv
package trace_pkg;

    // ************************************************************
    // Widths and depths
    // ************************************************************
    localparam int ADDR_W = 32;
    localparam int STAT_W = 3;
    localparam int NIB_W = 4;
    localparam int CNT_W = 16;
    localparam int MMD_NUM = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = STAT_W + ADDR_W;
    localparam int LVL_W = 3;

    // ************************************************************
    // Configuration selects written from the JTAG side
    // ************************************************************
    localparam logic [2:0] CFG_CTRL = 3'h0;
    localparam logic [2:0] CFG_RANGE_LO = 3'h1;
    localparam logic [2:0] CFG_RANGE_HI = 3'h2;
    localparam logic [2:0] CFG_COUNT = 3'h3;
    localparam logic [2:0] CFG_MMD = 3'h4;

    // Control word fields.
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_HALF_RATE = 1;
    localparam int CTRL_USE_RANGE = 2;
    localparam int CTRL_USE_MMD = 3;
    localparam int CTRL_USE_CNT = 4;
    localparam int CTRL_USE_EXT = 5;
    localparam int CTRL_SEL_LO = 2;
    localparam int CTRL_SEL_HI = 5;

    // Each decoder byte: enable bit and a match on the top nibble.
    localparam int MMD_EN_BIT = 7;

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [ADDR_W-1:0] RANGE_LO_RST = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] RANGE_HI_RST = 32'hFFFF_FFFF;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] MMD_RST = 32'h0000_0000;
    localparam logic [1:0] BYTES_AFTER_FIRST = 2'h3;
    localparam logic [LVL_W-1:0] STALL_LEVEL = 3'h3;

    typedef enum logic [2:0] {
        PS_EXEC = 3'b000,
        PS_SKIP = 3'b001,
        PS_WAIT = 3'b100,
        PS_OFF = 3'b101,
        PS_BRANCH = 3'b110
    } pstat_t;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_LOW = 2'b01,
        SER_HIGH = 2'b10
    } ser_state_t;

endpackage

// >>> core/instruction_trace_port.sv

// ****************************************************************
// Small FIFO between the core side and the trace port side
// ****************************************************************
module trace_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int LW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Fill level
    output logic [LW-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [LW-1:0] FULL = LW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [LW-1:0] level_q;
    logic push;
    logic pop;

    assign in_ready = (level_q != FULL);
    assign out_valid = (level_q != '0);
    assign out_data = mem[rd_q];
    assign level = level_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_q <= '0;
        end else if (push && !pop) begin
            level_q <= level_q + 1'b1;
        end else if (pop && !push) begin
            level_q <= level_q - 1'b1;
        end
    end
endmodule

// ****************************************************************
// Instruction trace port
// ****************************************************************
module instruction_trace_port import trace_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Core observation
    input wire logic core_cycle_valid,
    input wire logic core_instr_executed,
    input wire logic core_wait,
    input wire logic core_branch_taken,
    input wire logic [ADDR_W-1:0] core_branch_target,
    input wire logic [ADDR_W-1:0] core_instr_addr,
    input wire logic core_compressed_state,
    // Configuration from the JTAG side
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_sel,
    input wire logic [ADDR_W-1:0] cfg_wdata,
    // Pins from outside
    input wire logic trace_port_clock,
    input wire logic external_trigger_input,
    // Trace port
    output logic [STAT_W-1:0] pipeline_status_code,
    output logic branch_group_sync_flag,
    output logic [NIB_W-1:0] packet_nibble_out,
    // Core and power control
    output logic trace_buffer_stall_request,
    output logic trace_logic_idle
);

    // ************************************************************
    // Configuration
    // ************************************************************
    logic [7:0] ctrl_q;
    logic [ADDR_W-1:0] range_lo_q;
    logic [ADDR_W-1:0] range_hi_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] mmd_q;
    logic en;
    logic half_rate;

    assign en = ctrl_q[CTRL_ENABLE];
    assign half_rate = ctrl_q[CTRL_HALF_RATE];

    // The core has no path to these; only the debug scan side writes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
            range_lo_q <= RANGE_LO_RST;
            range_hi_q <= RANGE_HI_RST;
            mmd_q <= MMD_RST;
        end else if (cfg_wr) begin
            unique case (cfg_sel)
                CFG_CTRL: ctrl_q <= cfg_wdata[7:0];
                CFG_RANGE_LO: range_lo_q <= cfg_wdata;
                CFG_RANGE_HI: range_hi_q <= cfg_wdata;
                CFG_MMD: mmd_q <= cfg_wdata;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Pin sampling
    // ************************************************************
    logic tck_s1, tck_s2, tck_s3, tck_lvl_q;
    logic ext_s1, ext_s2, ext_s3, ext_lvl_q;
    logic tck_rise, tck_fall, ext_rise, slot;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tck_lvl_q <= 1'b0;
        end else begin
            tck_s1 <= trace_port_clock;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            if (tck_s2 == tck_s3) begin
                tck_lvl_q <= tck_s3;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            ext_lvl_q <= 1'b0;
        end else begin
            ext_s1 <= external_trigger_input;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3) begin
                ext_lvl_q <= ext_s3;
            end
        end
    end

    assign tck_rise = (tck_s2 == tck_s3) && tck_s3 && !tck_lvl_q;
    assign tck_fall = (tck_s2 == tck_s3) && !tck_s3 && tck_lvl_q;
    assign ext_rise = (ext_s2 == ext_s3) && ext_s3 && !ext_lvl_q;
    assign slot = tck_rise || (half_rate && tck_fall);

    // ************************************************************
    // Trigger resources
    // ************************************************************
    logic range_hit, mmd_hit, cnt_zero, gate, act_q;
    logic [MMD_NUM-1:0] mmd_match;

    // The counter counts external trigger events down to zero.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= COUNT_RST;
        end else if (cfg_wr && cfg_sel == CFG_COUNT) begin
            cnt_q <= cfg_wdata[CNT_W-1:0];
        end else if (en && ext_rise && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    for (genvar i = 0; i < MMD_NUM; i++) begin : g_mmd
        assign mmd_match[i] = mmd_q[8*i+MMD_EN_BIT] &&
            (core_instr_addr[ADDR_W-1 -: 4] == mmd_q[8*i +: 4]);
    end

    assign range_hit = (core_instr_addr >= range_lo_q) &&
        (core_instr_addr <= range_hi_q);
    assign mmd_hit = |mmd_match;
    assign cnt_zero = (cnt_q == '0);

    // With no resource selected everything is traced.
    assign gate = (ctrl_q[CTRL_SEL_HI:CTRL_SEL_LO] == '0) ||
        (ctrl_q[CTRL_USE_RANGE] && range_hit) ||
        (ctrl_q[CTRL_USE_MMD] && mmd_hit) ||
        (ctrl_q[CTRL_USE_CNT] && cnt_zero) ||
        (ctrl_q[CTRL_USE_EXT] && ext_lvl_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_q <= 1'b0;
        end else begin
            act_q <= en && gate;
        end
    end

    // ************************************************************
    // Core side encoding and buffering
    // ************************************************************
    logic [STAT_W-1:0] cyc_stat;
    logic [ADDR_W-1:0] cyc_addr;
    logic fifo_in_valid, fifo_in_ready;
    logic fifo_out_valid, fifo_out_ready;
    logic [FIFO_W-1:0] fifo_in_data, fifo_out_data;
    logic [LVL_W-1:0] fifo_level;
    logic stall_q, idle_q;

    // Only branch targets carry an address; the observation bus has
    // no data lines, so data values can never reach the port.
    always_comb begin
        cyc_addr = '0;
        if (core_wait) begin
            cyc_stat = PS_WAIT;
        end else if (core_branch_taken) begin
            cyc_stat = PS_BRANCH;
            cyc_addr = {core_branch_target[ADDR_W-1:1],
                core_compressed_state};
        end else if (core_instr_executed) begin
            cyc_stat = PS_EXEC;
        end else begin
            cyc_stat = PS_SKIP;
        end
    end

    assign fifo_in_valid = act_q && core_cycle_valid;
    assign fifo_in_data = {cyc_stat, cyc_addr};

    trace_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .LW(LVL_W)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready),
        .level(fifo_level)
    );

    // Stalling one entry early covers the registered stall latency.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stall_q <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            stall_q <= (fifo_level >= STALL_LEVEL) || !fifo_in_ready;
            idle_q <= !en;
        end
    end

    assign trace_buffer_stall_request = stall_q;
    assign trace_logic_idle = idle_q;

    // ************************************************************
    // Trace port serialiser
    // ************************************************************
    ser_state_t ser_q;
    logic [ADDR_W-1:0] sh_q;
    logic [1:0] left_q;
    logic [STAT_W-1:0] stat_q;
    logic sync_q;
    logic [NIB_W-1:0] nib_q;
    logic [STAT_W-1:0] head_stat;
    logic head_branch, pop;

    assign head_stat = fifo_out_data[FIFO_W-1 -: STAT_W];
    assign head_branch = (head_stat == PS_BRANCH);
    // A new branch group waits until the previous one has gone out.
    assign fifo_out_ready = slot && en &&
        (!head_branch || ser_q == SER_IDLE);
    assign pop = fifo_out_valid && fifo_out_ready;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_q <= PS_OFF;
        end else if (slot) begin
            if (pop) begin
                stat_q <= head_stat;
            end else begin
                stat_q <= en ? PS_WAIT : PS_OFF;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ser_q <= SER_IDLE;
            sh_q <= '0;
            left_q <= '0;
            sync_q <= 1'b0;
            nib_q <= '0;
        end else if (slot) begin
            unique case (ser_q)
                SER_IDLE: begin
                    if (pop && head_branch) begin
                        sh_q <= fifo_out_data[ADDR_W-1:0];
                        nib_q <= fifo_out_data[3:0];
                        left_q <= BYTES_AFTER_FIRST;
                        sync_q <= 1'b1;
                        ser_q <= SER_HIGH;
                    end else begin
                        nib_q <= '0;
                        sync_q <= 1'b0;
                    end
                end
                SER_HIGH: begin
                    nib_q <= sh_q[7:4];
                    sh_q <= {8'h00, sh_q[ADDR_W-1:8]};
                    ser_q <= (left_q == '0) ? SER_IDLE : SER_LOW;
                end
                SER_LOW: begin
                    nib_q <= sh_q[3:0];
                    sync_q <= 1'b0;
                    left_q <= left_q - 1'b1;
                    ser_q <= SER_HIGH;
                end
                default: ser_q <= SER_IDLE;
            endcase
        end
    end

    assign pipeline_status_code = stat_q;
    assign branch_group_sync_flag = sync_q;
    assign packet_nibble_out = nib_q;

    // ************************************************************
    // Checks
    // ************************************************************
    a_edge_launch: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(packet_nibble_out) |-> $past(slot))
        else $error("Nibble changed without a trace clock slot.");

    a_full_rate_fall: assert property (@(posedge clk) disable iff (sys_rst)
        (tck_fall && !half_rate) |=> $stable(pipeline_status_code))
        else $error("Status moved on a falling edge at full rate.");

    a_half_rate_fall: assert property (@(posedge clk) disable iff (sys_rst)
        (tck_fall && half_rate && ser_q == SER_LOW) |=> ser_q == SER_HIGH)
        else $error("Half-rate falling edge did not advance the packet.");

    a_status_from_head: assert property (@(posedge clk) disable iff (sys_rst)
        (slot && pop) |=> pipeline_status_code == $past(head_stat))
        else $error("Status code does not match the popped entry.");

    a_sync_first_pkt: assert property (@(posedge clk) disable iff (sys_rst)
        branch_group_sync_flag |-> left_q == BYTES_AFTER_FIRST)
        else $error("Sync flag high past the first packet.");

    a_nibble_order: assert property (@(posedge clk) disable iff (sys_rst)
        (slot && ser_q == SER_HIGH) |=> packet_nibble_out == $past(sh_q[7:4]))
        else $error("High nibble not sent after low nibble.");

    a_off_disabled: assert property (@(posedge clk) disable iff (sys_rst)
        (slot && !en) |=> pipeline_status_code == PS_OFF && !fifo_in_valid)
        else $error("Trace active while disabled.");

    a_compressed_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_in_valid && !core_wait && core_branch_taken) |->
        fifo_in_data[0] == core_compressed_state)
        else $error("Branch packet lost the instruction state bit.");

    a_ext_agree: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(ext_lvl_q) |-> $past(ext_s2) && $past(ext_s3))
        else $error("Trigger level rose before two stages agreed.");

endmodule

// >>> sim/trace_capture_model.sv
// ****************************************************************
// Trace capture analyzer on the far side of the trace port
// ****************************************************************
module trace_capture_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Trace port
    input wire logic trace_port_clock,
    input wire logic half_rate,
    input wire logic [2:0] pipeline_status_code,
    input wire logic branch_group_sync_flag,
    input wire logic [3:0] packet_nibble_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [6:0] dly_q = 7'h00;
    logic slot;
    int n_slot = 0;
    int n_err = 0;
    int idx = 8;
    logic [2:0] last_stat = 3'h0;
    logic [31:0] addr = 32'h0000_0000;
    logic [31:0] addr_q[$];

    // Sampling six clocks after the edge lands between the update for
    // this slot and the update for the next one, even at half rate.
    assign slot = half_rate ? (dly_q[5] != dly_q[6]) :
        (dly_q[5] && !dly_q[6]);

    always @(posedge clk) begin
        dly_q <= {dly_q[5:0], trace_port_clock};
        if (sys_rst) begin
            idx = 8;
        end else if (slot) begin
            n_slot = n_slot + 1;
            last_stat = pipeline_status_code;
            if (idx >= 8 && pipeline_status_code == 3'h6) begin
                idx = 0;
            end
            if (idx < 8) begin
                addr[4*idx +: 4] = packet_nibble_out;
                if (branch_group_sync_flag !== (idx < 2)) begin
                    n_err = n_err + 1;
                end
                idx = idx + 1;
                if (idx == 8) begin
                    addr_q.push_back(addr);
                end
            end else if (branch_group_sync_flag !== 1'b0 ||
                packet_nibble_out !== 4'h0) begin
                n_err = n_err + 1;
            end
        end
    end
endmodule

// >>> sim/test_instruction_trace_port.sv
module test_instruction_trace_port import trace_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Signals, design and analyzer
    // ************************************************************
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic core_cycle_valid = 1'b0;
    logic core_instr_executed = 1'b0;
    logic core_wait = 1'b0;
    logic core_branch_taken = 1'b0;
    logic [31:0] core_branch_target = 32'h0000_0000;
    logic [31:0] core_instr_addr = 32'h0000_0000;
    logic core_compressed_state = 1'b0;
    logic cfg_wr = 1'b0;
    logic [2:0] cfg_sel = 3'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic trace_port_clock = 1'b0;
    logic external_trigger_input = 1'b0;
    logic [2:0] pipeline_status_code;
    logic branch_group_sync_flag;
    logic [3:0] packet_nibble_out;
    logic trace_buffer_stall_request;
    logic trace_logic_idle;
    logic tclk_run = 1'b1;
    logic half_rate = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;

    instruction_trace_port i_dut (.clk, .sys_rst, .core_cycle_valid,
        .core_instr_executed, .core_wait, .core_branch_taken,
        .core_branch_target, .core_instr_addr, .core_compressed_state,
        .cfg_wr, .cfg_sel, .cfg_wdata, .trace_port_clock,
        .external_trigger_input, .pipeline_status_code,
        .branch_group_sync_flag, .packet_nibble_out,
        .trace_buffer_stall_request, .trace_logic_idle);

    trace_capture_model p (.clk, .sys_rst, .trace_port_clock, .half_rate,
        .pipeline_status_code, .branch_group_sync_flag,
        .packet_nibble_out);

    always #20 clk = ~clk;

    // The trace clock has its own phase and stands still when stopped.
    initial begin
        #7;
        forever begin
            #160;
            if (tclk_run) trace_port_clock = ~trace_port_clock;
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_sim();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic check_addr(input logic [31:0] exp);
        logic [31:0] got;
        got = 32'hXXXX_XXXX;
        if (p.addr_q.size() > 0) got = p.addr_q.pop_front();
        check_word(got, exp);
    endtask

    task automatic wait_slot(input int n);
        int k;
        k = p.n_slot + n;
        for (int i = 0; i < 40 * n && p.n_slot < k; i++) @(negedge clk);
        if (p.n_slot < k) begin
            n_mismatch++;
            $display("[ERR] %0t no trace slot", $time);
            end_sim();
        end
    endtask

    task automatic cfg(input logic [2:0] sel, input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_sel = sel;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask

    task automatic push(input logic ex, input logic wt, input logic br,
        input logic cs, input logic [31:0] tgt);
        @(negedge clk);
        core_cycle_valid = 1'b1;
        core_instr_executed = ex;
        core_wait = wt;
        core_branch_taken = br;
        core_compressed_state = cs;
        core_branch_target = tgt;
        @(negedge clk);
        core_cycle_valid = 1'b0;
        core_branch_taken = 1'b0;
        core_wait = 1'b0;
    endtask

    task automatic do_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
    endtask

    // ************************************************************
    // Cases
    // ************************************************************
    typedef struct packed {
        logic ex; logic wt; logic br; logic cs; logic [31:0] tgt;
        logic [2:0] st;
    } row_t;
    typedef struct packed {
        logic [7:0] ctrl; logic [31:0] ia; logic [1:0] edges;
        logic ext; logic stall;
    } gate_t;

    row_t rows [6] = '{
        '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000, PS_EXEC},
        '{1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0000, PS_SKIP},
        '{1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_0000, PS_WAIT},
        '{1'b1, 1'b1, 1'b1, 1'b0, 32'h1234_5678, PS_WAIT},
        '{1'b1, 1'b0, 1'b1, 1'b0, 32'hA5C3_0F96, PS_BRANCH},
        '{1'b1, 1'b0, 1'b1, 1'b1, 32'h8765_4320, PS_BRANCH}};

    gate_t gates [8] = '{
        '{8'h05, 32'h1800_0000, 2'h0, 1'b0, 1'b1},
        '{8'h05, 32'h2000_0000, 2'h0, 1'b0, 1'b0},
        '{8'h09, 32'h4000_0000, 2'h0, 1'b0, 1'b1},
        '{8'h09, 32'h5000_0000, 2'h0, 1'b0, 1'b0},
        '{8'h11, 32'h0000_0000, 2'h1, 1'b0, 1'b0},
        '{8'h11, 32'h0000_0000, 2'h2, 1'b0, 1'b1},
        '{8'h21, 32'h0000_0000, 2'h0, 1'b0, 1'b0},
        '{8'h21, 32'h0000_0000, 2'h0, 1'b1, 1'b1}};

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        check_word(pipeline_status_code, PS_OFF);
        check_bit(branch_group_sync_flag, 1'b0);
        check_word(packet_nibble_out, 4'h0);
        check_bit(trace_buffer_stall_request, 1'b0);
        check_bit(trace_logic_idle, 1'b1);
        push(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0040);
        wait_slot(2);
        check_word(p.last_stat, PS_OFF);
        cfg(CFG_CTRL, 32'h0000_0001);
        repeat (2) @(negedge clk);
        check_bit(trace_logic_idle, 1'b0);
        foreach (rows[i]) begin
            wait_slot(1);
            push(rows[i].ex, rows[i].wt, rows[i].br, rows[i].cs, rows[i].tgt);
            wait_slot(1);
            check_word(p.last_stat, rows[i].st);
            if (rows[i].st == PS_BRANCH) begin
                wait_slot(7);
                check_addr({rows[i].tgt[31:1], rows[i].cs});
            end
        end
        // A second branch arrives before the first group has gone out.
        push(1'b1, 1'b0, 1'b1, 1'b1, 32'h0F0F_1E2C);
        push(1'b1, 1'b0, 1'b1, 1'b0, 32'hF0E1_D2C4);
        wait_slot(20);
        check_addr(32'h0F0F_1E2D);
        check_addr(32'hF0E1_D2C4);
        cfg(CFG_CTRL, 32'h0000_0003);
        half_rate = 1'b1;
        push(1'b1, 1'b0, 1'b1, 1'b0, 32'h9ABC_DEF0);
        wait_slot(12);
        check_addr(32'h9ABC_DEF0);
        cfg(CFG_CTRL, 32'h0000_0001);
        half_rate = 1'b0;
        tclk_run = 1'b0;
        repeat (10) @(negedge clk);
        repeat (5) push(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
        repeat (2) @(negedge clk);
        check_bit(trace_buffer_stall_request, 1'b1);
        tclk_run = 1'b1;
        wait_slot(6);
        check_bit(trace_buffer_stall_request, 1'b0);
        check_word(p.addr_q.size(), 32'h0000_0000);
        tclk_run = 1'b0;
        foreach (gates[i]) begin
            do_reset();
            external_trigger_input = gates[i].ext;
            core_instr_addr = gates[i].ia;
            cfg(CFG_RANGE_LO, 32'h1000_0000);
            cfg(CFG_RANGE_HI, 32'h1FFF_FFFF);
            cfg(CFG_COUNT, 32'h0000_0002);
            cfg(CFG_MMD, 32'h0000_0084);
            cfg(CFG_CTRL, {24'h00_0000, gates[i].ctrl});
            repeat (gates[i].edges) begin
                @(negedge clk);
                external_trigger_input = 1'b1;
                repeat (5) @(negedge clk);
                external_trigger_input = 1'b0;
                repeat (4) @(negedge clk);
            end
            repeat (6) @(negedge clk);
            repeat (3) push(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
            repeat (2) @(negedge clk);
            check_bit(trace_buffer_stall_request, gates[i].stall);
        end
        check_word(p.n_err, 32'h0000_0000);
        end_sim();
    end
endmodule
